// ### hw/pmc_pin_cell.sv
// per-pin ownership mux between port registers and shared peripherals
// assumes pure combinational use; the caller registers every result except pinRead
`timescale 1ns/10ps
module pmc_pin_cell #(
  parameter int unsigned WIDTH = 22
) (
  input  wire logic [WIDTH-1:0] dirIn,
  input  wire logic [WIDTH-1:0] latchVal,
  input  wire logic [WIDTH-1:0] digitalCfg,
  input  wire logic [WIDTH-1:0] padLevel,
  input  wire logic [WIDTH-1:0] perOutOwn,
  input  wire logic [WIDTH-1:0] perBidirOwn,
  input  wire logic [WIDTH-1:0] perSerialOwn,
  input  wire logic [WIDTH-1:0] perAnaOutOwn,
  input  wire logic [WIDTH-1:0] perOutData,
  input  wire logic [WIDTH-1:0] perOutEn,
  input  wire logic [WIDTH-1:0] perTriState,
  output logic      [WIDTH-1:0] coreOe,
  output logic      [WIDTH-1:0] coreOut,
  output logic      [WIDTH-1:0] anaDrive,
  output logic      [WIDTH-1:0] pinRead,
  output logic      [WIDTH-1:0] perIn
);

  logic [WIDTH-1:0] analogUse;

  always_comb
  begin
    analogUse = ~digitalCfg | perAnaOutOwn;
    for (int i = 0; i < WIDTH; i++)
    begin
      coreOe[i]  = ~dirIn[i];
      coreOut[i] = latchVal[i];
      if (perSerialOwn[i])
      begin
        coreOe[i]  = perOutEn[i];
        coreOut[i] = perOutData[i];
      end
      else if (perBidirOwn[i])
      begin
        coreOe[i]  = perOutEn[i] | ~dirIn[i];
        coreOut[i] = perOutData[i];
      end
      else if (perOutOwn[i])
      begin
        coreOe[i]  = ~dirIn[i];
        coreOut[i] = perOutData[i];
      end
      if (perTriState[i] || analogUse[i])
      begin
        coreOe[i] = 1'b0;
      end
      anaDrive[i] = perAnaOutOwn[i];
      pinRead[i]  = analogUse[i] ? 1'b0 : padLevel[i];
      if (analogUse[i])
      begin
        perIn[i] = 1'b0;
      end
      else if (perSerialOwn[i])
      begin
        perIn[i] = padLevel[i];
      end
      else
      begin
        perIn[i] = coreOe[i] ? coreOut[i] : padLevel[i];
      end
    end
  end

endmodule : pmc_pin_cell

// ### hw/pmc_top.sv
// shared port pins with change notice detection behind an apb slave
// assumes pads resolve the wire from padOe; pad inputs are asynchronous
`timescale 1ns/10ps
module pmc_top #(
  parameter int unsigned PINS = pmc_pkg::PIN_COUNT
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pmc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pmc_pkg::DATA_W-1:0]  pwdata,
  output logic      [pmc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [PINS-1:0]             padIn,
  output logic      [PINS-1:0]             padOut,
  output logic      [PINS-1:0]             padOe,
  output logic      [PINS-1:0]             padAnalogDrive,
  output logic      [PINS-1:0]             padPullupEn,
  input  wire logic [PINS-1:0]             perOutOwn,
  input  wire logic [PINS-1:0]             perBidirOwn,
  input  wire logic [PINS-1:0]             perSerialOwn,
  input  wire logic [PINS-1:0]             perAnaOutOwn,
  input  wire logic [PINS-1:0]             perOutData,
  input  wire logic [PINS-1:0]             perOutEn,
  input  wire logic [PINS-1:0]             perTriState,
  output logic      [PINS-1:0]             perIn,
  input  wire logic                        scanEnable,
  input  wire logic [PINS-1:0]             scanOe,
  input  wire logic [PINS-1:0]             scanOut,
  input  wire logic                        cpuIdle,
  output logic                             changeRequest,
  output logic                             changeIrqFlag,
  output logic                             changeIrqActive
);

  // register state
  logic [PINS-1:0]  dir_q;
  logic [PINS-1:0]  latch_q;
  logic [PINS-1:0]  anaCfg_q;
  logic [PINS-1:0]  chgEn_q;
  logic [PINS-1:0]  pullup_q;
  logic [15:0]      ctrl_q;
  logic             irqFlag_q;
  logic             irqEn_q;
  logic [2:0]       irqPrio_q;
  logic [1:0]       irqSub_q;

  // pin sampling and change detection state
  logic [PINS-1:0]  padMeta_q;
  logic [PINS-1:0]  padSync_q;
  logic [PINS-1:0]  padHeld_q;
  logic [PINS-1:0]  ref_q;
  logic [PINS-1:0]  mism_q;
  logic [PINS-1:0]  readSnap_q;

  // bus state
  pmc_pkg::pmc_apb_e apbState_q;
  logic [pmc_pkg::DATA_W-1:0] prdata_q;
  logic             pready_q;
  logic             pslverr_q;

  // registered outputs
  logic [PINS-1:0]  padOut_q;
  logic [PINS-1:0]  padOe_q;
  logic [PINS-1:0]  padAna_q;
  logic [PINS-1:0]  pullupOut_q;
  logic [PINS-1:0]  perIn_q;
  logic             changeReq_q;
  logic             irqActive_q;

  // combinational nets
  logic [PINS-1:0]  coreOe;
  logic [PINS-1:0]  coreOut;
  logic [PINS-1:0]  anaDrive;
  logic [PINS-1:0]  pinRead;
  logic [PINS-1:0]  perInComb;
  logic [PINS-1:0]  padLevel;
  logic [PINS-1:0]  mism_d;
  logic [pmc_pkg::DATA_W-1:0] readData;
  logic             setupPhase;
  logic             writeDone;
  logic             readDone;
  logic             detectOn;
  logic             anyMism;

  function automatic logic addrHit(input logic [pmc_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0]                 offset);
    addrHit = (addr == offset);
  endfunction : addrHit

  function automatic logic addrMapped(input logic [pmc_pkg::ADDR_W-1:0] addr);
    addrMapped = addrHit(addr, pmc_pkg::OFF_DIR)    || addrHit(addr, pmc_pkg::OFF_PINRD)  ||
                 addrHit(addr, pmc_pkg::OFF_LATCH)  || addrHit(addr, pmc_pkg::OFF_ANACFG) ||
                 addrHit(addr, pmc_pkg::OFF_CTRL)   || addrHit(addr, pmc_pkg::OFF_CHGEN)  ||
                 addrHit(addr, pmc_pkg::OFF_PULLUP) || addrHit(addr, pmc_pkg::OFF_IRQ)    ||
                 addrHit(addr, pmc_pkg::OFF_MISM);
  endfunction : addrMapped

  function automatic logic [pmc_pkg::DATA_W-1:0] widen(input logic [PINS-1:0] v);
    widen = {{(pmc_pkg::DATA_W-PINS){1'b0}}, v};
  endfunction : widen

  assign setupPhase = psel & ~penable;
  assign writeDone  = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign readDone   = psel & penable & pready_q & ~pwrite & addrHit(paddr, pmc_pkg::OFF_PINRD);
  assign detectOn   = ctrl_q[pmc_pkg::CTRL_ON_BIT];

  pmc_pin_cell #(
    .WIDTH        (PINS)
  ) pmc_pin_cell_inst (
    .dirIn        (dir_q),
    .latchVal     (latch_q),
    .digitalCfg   (anaCfg_q),
    .padLevel     (padLevel),
    .perOutOwn    (perOutOwn),
    .perBidirOwn  (perBidirOwn),
    .perSerialOwn (perSerialOwn),
    .perAnaOutOwn (perAnaOutOwn),
    .perOutData   (perOutData),
    .perOutEn     (perOutEn),
    .perTriState  (perTriState),
    .coreOe       (coreOe),
    .coreOut      (coreOut),
    .anaDrive     (anaDrive),
    .pinRead      (pinRead),
    .perIn        (perInComb)
  );

  // pad synchroniser; idle with stop-in-idle holds the synced view
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      padMeta_q <= '0;
      padSync_q <= '0;
    end
    else
    begin
      padMeta_q <= padIn;
      padSync_q <= padMeta_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      padHeld_q <= '0;
    end
    else if (!(cpuIdle && ctrl_q[pmc_pkg::CTRL_STOP_IN_IDLE_BIT]))
    begin
      padHeld_q <= padSync_q;
    end
  end

  // sampling continues in idle; only the synchronised update is frozen
  assign padLevel = (cpuIdle && ctrl_q[pmc_pkg::CTRL_STOP_IN_IDLE_BIT]) ? padHeld_q : padSync_q;

  // software registers; direction resets to inputs, zero analog config means analog
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dir_q     <= pmc_pkg::RST_DIR;
      latch_q   <= pmc_pkg::RST_LATCH;
      anaCfg_q  <= pmc_pkg::RST_ANACFG;
      ctrl_q    <= pmc_pkg::RST_CTRL;
      chgEn_q   <= pmc_pkg::RST_CHGEN;
      pullup_q  <= pmc_pkg::RST_PULLUP;
      irqEn_q   <= 1'b0;
      irqPrio_q <= pmc_pkg::RST_PRIO;
      irqSub_q  <= pmc_pkg::RST_SUB;
    end
    else if (writeDone)
    begin
      if (addrHit(paddr, pmc_pkg::OFF_DIR))
        dir_q <= pwdata[PINS-1:0];
      if (addrHit(paddr, pmc_pkg::OFF_LATCH))
        latch_q <= pwdata[PINS-1:0];
      if (addrHit(paddr, pmc_pkg::OFF_ANACFG))
        anaCfg_q <= pwdata[PINS-1:0];
      if (addrHit(paddr, pmc_pkg::OFF_CHGEN))
        chgEn_q <= pwdata[PINS-1:0];
      if (addrHit(paddr, pmc_pkg::OFF_PULLUP))
        pullup_q <= pwdata[PINS-1:0];
      if (addrHit(paddr, pmc_pkg::OFF_CTRL))
      begin
        ctrl_q <= '0;
        ctrl_q[pmc_pkg::CTRL_ON_BIT]   <= pwdata[pmc_pkg::CTRL_ON_BIT];
        ctrl_q[pmc_pkg::CTRL_STOP_IN_IDLE_BIT] <= pwdata[pmc_pkg::CTRL_STOP_IN_IDLE_BIT];
      end
      if (addrHit(paddr, pmc_pkg::OFF_IRQ))
      begin
        irqEn_q   <= pwdata[pmc_pkg::IRQ_EN_BIT];
        irqPrio_q <= pwdata[pmc_pkg::IRQ_PRIO_LSB +: pmc_pkg::IRQ_PRIO_W];
        irqSub_q  <= pwdata[pmc_pkg::IRQ_SUB_LSB +: pmc_pkg::IRQ_SUB_W];
      end
    end
  end

  // sticky flag; writing one clears it, a pending change wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irqFlag_q <= 1'b0;
    end
    else if (anyMism)
    begin
      irqFlag_q <= 1'b1;
    end
    else if (writeDone && addrHit(paddr, pmc_pkg::OFF_IRQ) && pwdata[pmc_pkg::IRQ_FLAG_BIT])
    begin
      irqFlag_q <= 1'b0;
    end
  end

  // change detection against the reference of the last pin read
  always_comb
  begin
    mism_d = mism_q;
    if (readDone)
    begin
      mism_d = '0;
    end
    for (int i = 0; i < PINS; i++)
    begin
      if (detectOn && chgEn_q[i] && dir_q[i]
          && (pinRead[i] != (readDone ? readSnap_q[i] : ref_q[i])))
      begin
        mism_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mism_q <= '0;
      ref_q  <= '0;
    end
    else
    begin
      mism_q <= mism_d;
      if (readDone)
      begin
        ref_q <= readSnap_q;
      end
    end
  end

  assign anyMism = |(mism_q & chgEn_q) & detectOn;

  // read mux
  always_comb
  begin
    readData = '0;
    unique case (1'b1)
      addrHit(paddr, pmc_pkg::OFF_DIR):    readData = widen(dir_q);
      addrHit(paddr, pmc_pkg::OFF_PINRD):  readData = widen(pinRead);
      addrHit(paddr, pmc_pkg::OFF_LATCH):  readData = widen(latch_q);
      addrHit(paddr, pmc_pkg::OFF_ANACFG): readData = widen(anaCfg_q);
      addrHit(paddr, pmc_pkg::OFF_CTRL):   readData[15:0] = ctrl_q;
      addrHit(paddr, pmc_pkg::OFF_CHGEN):  readData = widen(chgEn_q);
      addrHit(paddr, pmc_pkg::OFF_PULLUP): readData = widen(pullup_q);
      addrHit(paddr, pmc_pkg::OFF_IRQ):
      begin
        readData[pmc_pkg::IRQ_FLAG_BIT] = irqFlag_q;
        readData[pmc_pkg::IRQ_EN_BIT]   = irqEn_q;
        readData[pmc_pkg::IRQ_PRIO_LSB +: pmc_pkg::IRQ_PRIO_W] = irqPrio_q;
        readData[pmc_pkg::IRQ_SUB_LSB +: pmc_pkg::IRQ_SUB_W]   = irqSub_q;
      end
      addrHit(paddr, pmc_pkg::OFF_MISM):   readData = widen(mism_q);
      default:                             readData = '0;
    endcase
  end

  // apb slave: data latched in setup, one access cycle with pready
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      apbState_q <= pmc_pkg::APB_IDLE;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= '0;
      readSnap_q <= '0;
    end
    else
    begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase & ~addrMapped(paddr);
      if (setupPhase)
      begin
        apbState_q <= pmc_pkg::APB_ACCESS;
        prdata_q   <= (pwrite || !addrMapped(paddr)) ? '0 : readData;
        readSnap_q <= pinRead;
      end
      else if (psel)
      begin
        apbState_q <= pmc_pkg::APB_SETUP;
      end
      else
      begin
        apbState_q <= pmc_pkg::APB_IDLE;
        prdata_q   <= '0;
      end
    end
  end

  // pad drive through the bypassed scan cell
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      padOut_q    <= '0;
      padOe_q     <= '0;
      padAna_q    <= '0;
      pullupOut_q <= '0;
      perIn_q     <= '0;
    end
    else
    begin
      padOut_q    <= scanEnable ? scanOut : coreOut;
      padOe_q     <= scanEnable ? scanOe  : coreOe;
      padAna_q    <= anaDrive;
      pullupOut_q <= pullup_q;
      perIn_q     <= perInComb;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      changeReq_q <= 1'b0;
      irqActive_q <= 1'b0;
    end
    else
    begin
      changeReq_q <= anyMism;
      irqActive_q <= irqFlag_q & irqEn_q & (irqPrio_q != 3'h0);
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign padOut          = padOut_q;
  assign padOe           = padOe_q;
  assign padAnalogDrive  = padAna_q;
  assign padPullupEn     = pullupOut_q;
  assign perIn           = perIn_q;
  assign changeRequest   = changeReq_q;
  assign changeIrqFlag   = irqFlag_q;
  assign changeIrqActive = irqActive_q;

endmodule : pmc_top

// ### pkg/pmc_pkg.sv
// constants shared by the pin mux and change notice block
// assumes an apb master with 32-bit data and a 20 mhz system clock
// How it works
// - input peripheral gets its own path; pin read still shows real level
// - input peripheral never touches direction; software sets direction to input
// - output peripheral supplies pin data; output latch has no effect
// - peripheral tri-state request floats the pin whatever the port settings
// - bidirectional peripheral forces output; input needs direction bit set
// - bidirectional peripheral drives data; latch ignored; pin read shows pin
// - analog use disables digital input buffers; pin read returns zero
// - analog output drives the pin regardless of direction bit
// - capture-style inputs see the output latch when pin is output
// - enabled serial peripherals own pins; port registers cannot affect them, except analog config, which still floats the pin and zeroes its input
// - scan cell bypassed in normal use; enable and data pass straight through
// - change detection only on enabled input pins, up to 22
// - compare pin with value captured at last pin read; flag mismatch
// - all pin mismatches are ored into one change request
// - enabled change pins are sampled every system clock
// - change pull-up enabled by its bit in pull-up enable register
// - change detection runs only while control bit 15 is one
// - pin read clears mismatch and captures a new reference
// - change sets the irq flag, held until software clears it
// - stop-in-idle bit 13 chooses idle synchronisation; sampling continues
package pmc_pkg;

  localparam int unsigned PIN_COUNT  = 22;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;

  localparam logic [7:0] OFF_DIR     = 8'h00;
  localparam logic [7:0] OFF_PINRD   = 8'h04;
  localparam logic [7:0] OFF_LATCH   = 8'h08;
  localparam logic [7:0] OFF_ANACFG  = 8'h0c;
  localparam logic [7:0] OFF_CTRL    = 8'h10;
  localparam logic [7:0] OFF_CHGEN   = 8'h14;
  localparam logic [7:0] OFF_PULLUP  = 8'h18;
  localparam logic [7:0] OFF_IRQ     = 8'h1c;
  localparam logic [7:0] OFF_MISM    = 8'h20;

  localparam int unsigned CTRL_ON_BIT   = 15;
  localparam int unsigned CTRL_STOP_IN_IDLE_BIT = 13;

  localparam int unsigned IRQ_FLAG_BIT  = 0;
  localparam int unsigned IRQ_EN_BIT    = 1;
  localparam int unsigned IRQ_PRIO_LSB  = 2;
  localparam int unsigned IRQ_PRIO_W    = 3;
  localparam int unsigned IRQ_SUB_LSB   = 5;
  localparam int unsigned IRQ_SUB_W     = 2;

  localparam logic [PIN_COUNT-1:0] RST_DIR    = 22'h3fffff;
  localparam logic [PIN_COUNT-1:0] RST_LATCH  = 22'h000000;
  localparam logic [PIN_COUNT-1:0] RST_ANACFG = 22'h000000;
  localparam logic [PIN_COUNT-1:0] RST_CHGEN  = 22'h000000;
  localparam logic [PIN_COUNT-1:0] RST_PULLUP = 22'h000000;
  localparam logic [15:0]          RST_CTRL   = 16'h0000;
  localparam logic [2:0]           RST_PRIO   = 3'h0;
  localparam logic [1:0]           RST_SUB    = 2'h0;

  typedef enum logic [2:0]
  {
    APB_IDLE   = 3'b001,
    APB_SETUP  = 3'b010,
    APB_ACCESS = 3'b100
  } pmc_apb_e;

endpackage : pmc_pkg

// ### verif/pin_mux_change_notify_test.sv
// self-checking bench for the pin mux and change notice block
// assumes apb answers without wait states; pads seen two cycles late
`timescale 1ns/10ps
module pin_mux_change_notify_test;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        scanEnable, cpuIdle, changeRequest, changeIrqFlag, changeIrqActive;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [21:0] padIn, padOut, padOe, padAnalogDrive, padPullupEn, perIn, scanOe, scanOut;
  logic [21:0] perOutOwn, perBidirOwn, perSerialOwn, perAnaOutOwn, perOutData, perOutEn;
  logic [21:0] perTriState, extDrive, extVal;
  logic        e;
  int          mismatches = 0;
  int          n_compared = 0;
  pmc_top pmc_top_inst (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .padIn, .padOut, .padOe, .padAnalogDrive, .padPullupEn, .perOutOwn,
    .perBidirOwn, .perSerialOwn, .perAnaOutOwn, .perOutData, .perOutEn, .perTriState, .perIn,
    .scanEnable, .scanOe, .scanOut, .cpuIdle, .changeRequest, .changeIrqFlag, .changeIrqActive);
  pmc_pad_env pmc_pad_env_inst (.sys_clk, .padOut, .padOe, .padPullupEn, .extDrive, .extVal,
    .padIn);
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q, x);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wait_req(input logic x);
    int n;
    n = 0;
    while (changeRequest !== x && n < 10)
    begin
      n++;
      @(posedge sys_clk);
    end
    check(changeRequest, x);
  endtask : wait_req
  task automatic test_pins();
    rd(8'h00, 32'h3fffff);
    rd(8'h10, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check({q[31:1], e}, 32'h1);
    apb(1'b1, 8'h0c, 32'h3fffff);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'h155555);
    tick(3);
    check(padOe, 32'h3fffff);
    check(padOut, 32'h155555);
    check(perIn, 32'h155555);
    perOutOwn <= '1;
    perOutData <= 22'h2aaaaa;
    tick(4);
    check(padOut, 32'h2aaaaa);
    rd(8'h04, 32'h2aaaaa);
    perOutOwn <= '0;
    perBidirOwn <= '1;
    apb(1'b1, 8'h00, 32'h3fffff);
    extDrive <= '1;
    extVal <= 22'h0f0f0f;
    tick(4);
    check(padOe, 32'h0);
    rd(8'h04, 32'h0f0f0f);
    perOutEn <= '1;
    extDrive <= '0;
    tick(2);
    check(padOe, 32'h3fffff);
    check(padOut, 32'h2aaaaa);
    perBidirOwn <= '0;
    perSerialOwn <= '1;
    perOutEn <= '0;
    apb(1'b1, 8'h00, 32'h0);
    extDrive <= '1;
    tick(4);
    check(perIn, 32'h0f0f0f);
    perSerialOwn <= '0;
    $display("pin ownership test done");
  endtask : test_pins
  task automatic test_analog();
    apb(1'b1, 8'h00, 32'h3fffff);
    extVal <= '1;
    apb(1'b1, 8'h0c, 32'h3ff000);
    perAnaOutOwn <= 22'h000001;
    tick(4);
    rd(8'h04, 32'h3ff000);
    check(perIn, 32'h3ff000);
    check(padAnalogDrive, 32'h1);
    perAnaOutOwn <= '0;
    extDrive <= '0;
    apb(1'b1, 8'h0c, 32'h3fffff);
    apb(1'b1, 8'h00, 32'h0);
    perTriState <= 22'h00000f;
    tick(3);
    check(padOe, 32'h3ffff0);
    perTriState <= '0;
    scanEnable <= 1'b1;
    scanOe <= 22'h00003c;
    scanOut <= 22'h000005;
    tick(2);
    check(padOe, 32'h3c);
    check(padOut, 32'h5);
    scanEnable <= 1'b0;
    $display("analog and tri-state test done");
  endtask : test_analog
  task automatic test_change();
    apb(1'b1, 8'h00, 32'h3fffff);
    apb(1'b1, 8'h10, 32'h8000);
    apb(1'b1, 8'h14, 32'h12);
    apb(1'b1, 8'h18, 32'h12);
    tick(4);
    check(padPullupEn, 32'h12);
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h1c, 32'h77);
    tick(8);
    check({changeRequest, changeIrqFlag}, 32'h0);
    extDrive <= 22'h000010;
    extVal <= '0;
    wait_req(1'b1);
    tick(2);
    check({changeIrqFlag, changeIrqActive}, 32'h3);
    tick(20);
    check(changeRequest, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    wait_req(1'b0);
    check(changeIrqFlag, 32'h1);
    apb(1'b1, 8'h1c, 32'h77);
    tick(2);
    check(changeIrqFlag, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    extVal <= '1;
    tick(10);
    check(changeRequest, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h10, 32'ha000);
    cpuIdle <= 1'b1;
    extVal <= '0;
    tick(10);
    check(changeRequest, 32'h0);
    cpuIdle <= 1'b0;
    wait_req(1'b1);
    $display("change notice test done");
  endtask : test_change
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200us;
    mismatches++;
    stop_test();
  end
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {scanEnable, cpuIdle, scanOe, scanOut, extDrive, extVal} = '0;
    {perOutOwn, perBidirOwn, perSerialOwn, perAnaOutOwn} = '0;
    {perOutData, perOutEn, perTriState} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    test_pins();
    test_analog();
    test_change();
    stop_test();
  end
endmodule : pin_mux_change_notify_test

// ### verif/pmc_pad_env.sv
// external devices on the pads: drivers, pull-ups, floating lines
// assumes the bench sets extDrive only where the block does not drive
`timescale 1ns/10ps
module pmc_pad_env #(
  parameter int unsigned PINS = 22
) (
  input  wire logic            sys_clk,
  input  wire logic [PINS-1:0] padOut,
  input  wire logic [PINS-1:0] padOe,
  input  wire logic [PINS-1:0] padPullupEn,
  input  wire logic [PINS-1:0] extDrive,
  input  wire logic [PINS-1:0] extVal,
  output logic      [PINS-1:0] padIn
);
  logic [PINS-1:0] float_q = '0;
  always_ff @(posedge sys_clk)
  begin
    float_q <= ~float_q;
  end
  // undriven lines without a pull-up wander every cycle
  assign padIn = (padOe & padOut) | (~padOe & extDrive & extVal)
               | (~padOe & ~extDrive & padPullupEn)
               | (~padOe & ~extDrive & ~padPullupEn & float_q);
endmodule : pmc_pad_env

// ### verif/pmc_top_props.sv
// port assertions for the pin mux and change notice block
// assumes a bind onto pmc_top; pads and registers settle one edge late
`timescale 1ns/10ps
module pmc_top_props #(
  parameter int unsigned PINS = 22
) (
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [PINS-1:0] padOut,
  input wire logic [PINS-1:0] padOe,
  input wire logic [PINS-1:0] padAnalogDrive,
  input wire logic [PINS-1:0] perIn,
  input wire logic [PINS-1:0] perOutOwn,
  input wire logic [PINS-1:0] perAnaOutOwn,
  input wire logic [PINS-1:0] perOutData,
  input wire logic [PINS-1:0] perTriState,
  input wire logic            scanEnable,
  input wire logic            changeRequest,
  input wire logic            changeIrqFlag,
  input wire logic            changeIrqActive
);
  logic irqClr;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // write one to the flag bit
  assign irqClr = psel && penable && pwrite && paddr == 8'h1c && pwdata[0];
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  flag_hold_a: assert property (changeIrqFlag && !irqClr |=> changeIrqFlag)
    else $error("flag dropped");
  flag_set_a: assert property ($rose(changeRequest) |-> changeIrqFlag)
    else $error("request without flag");
  active_flag_a: assert property (changeIrqActive
    |-> changeIrqFlag || $past(changeIrqFlag))
    else $error("active without flag");
  tristate_oe_a: assert property (!$past(scanEnable)
    |-> (padOe & $past(perTriState)) == '0)
    else $error("tri-state pin driven");
  analog_pad_a: assert property (!$past(scanEnable)
    |-> (padOe & $past(perAnaOutOwn)) == '0
    && ($past(perAnaOutOwn) & ~padAnalogDrive) == '0)
    else $error("analog pin wrong");
  analog_in_a: assert property ((perIn & $past(perAnaOutOwn)) == '0)
    else $error("analog pin seen digital");
  outown_data_a: assert property (!$past(scanEnable)
    |-> (padOe & $past(perOutOwn) & (padOut ^ $past(perOutData))) == '0)
    else $error("owned pin data wrong");
endmodule : pmc_top_props

bind pmc_top pmc_top_props #(.PINS(PINS)) pmc_top_props_inst (.sys_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .padOut, .padOe, .padAnalogDrive,
  .perIn, .perOutOwn, .perAnaOutOwn, .perOutData, .perTriState, .scanEnable, .changeRequest,
  .changeIrqFlag, .changeIrqActive);
